// ---- hdl/srcl_diff_out.sv ----
/*
 * One differential serial output stage: registered true/complement pair,
 * held static with opposite levels while muted.
 * Assumes data is already chosen and mute already resolved by the caller.
 */
`timescale 1ns/1ps
`default_nettype none

module srcl_diff_out (
    // Clock and reset
    input  wire logic               hclk,
    input  wire logic               hresetn,
    // Source
    input  wire logic               mute,
    input  wire logic               data,
    // Pin pair
    output srcl_pkg::srcl_diff_t    pair
);
    import srcl_pkg::*;

    srcl_diff_t next_pair;

    assign next_pair = mute ? DIFF_MUTED : srcl_diff_t'{p: data, n: ~data};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pair <= DIFF_MUTED;
        end else begin
            pair <= next_pair;
        end
    end

endmodule

`default_nettype wire

// ---- hdl/srcl_pkg.sv ----
/*
 * Shared constants, types and decode functions of the serial reclocker
 * control block: register map, field layouts, reset values, rate codes
 * and timing counts.
 * Assumes a 100 MHz system clock and a 27 MHz reference timing rate.
 */
package srcl_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS     = 10;
    localparam int unsigned LOCK_DROP_MAX_NS  = 1000000;
    // Longest time: round down
    localparam int unsigned LOCK_DROP_MAX_CYC = LOCK_DROP_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned HOLD_W            = 17;

    // Reference tick: 27 MHz out of 100 MHz by fractional accumulation
    localparam int unsigned ACC_W    = 7;
    localparam logic [6:0]  REF_STEP = 7'h1b;
    localparam logic [6:0]  REF_WRAP = 7'h64;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [31:0] CTRL_ADDR   = 32'h0000_0000;
    localparam logic [31:0] STATUS_ADDR = 32'h0000_0004;
    localparam logic [1:0]  HTRANS_NSEQ_BIT = 2'h2;
    localparam logic [2:0]  HSIZE_WORD  = 3'h2;
    localparam int unsigned REG_W       = 8;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RC_AUTO,
        RC_SD270,
        RC_HD,
        RC_TEST
    } srcl_rate_choice_t;

    typedef enum logic [2:0] {
        RATE_NONE,
        RATE_143,
        RATE_270,
        RATE_1483,
        RATE_1485,
        RATE_177,
        RATE_360,
        RATE_540
    } srcl_rate_t;

    typedef struct packed {
        logic              mute_follow_lock;
        srcl_rate_choice_t rate_choice;
        logic              second_out_clock_choice;
        logic              bypass;
        logic              mute_n;
        logic [1:0]        channel;
    } srcl_ctrl_t;

    typedef struct packed {
        srcl_rate_t detected_rate;
        logic       settling;
        logic       muted;
        logic       reclocking;
        logic       standard_def_flag;
        logic       lock_flag;
    } srcl_status_t;

    typedef struct packed {
        logic p;
        logic n;
    } srcl_diff_t;

    // Outputs enabled, automatic bypass, data on second output, input 0
    localparam srcl_ctrl_t CTRL_RESET = '{
        mute_follow_lock        : 1'b0,
        rate_choice             : RC_AUTO,
        second_out_clock_choice : 1'b0,
        bypass                  : 1'b0,
        mute_n                  : 1'b1,
        channel                 : 2'h0
    };

    // Static muted state: true and complement opposite
    localparam srcl_diff_t DIFF_MUTED = '{p: 1'b0, n: 1'b1};

    // ------------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------------
    function automatic logic rate_is_sd(input srcl_rate_t rate);
        rate_is_sd = (rate == RATE_143) || (rate == RATE_270);
    endfunction

    function automatic logic rate_is_hd(input srcl_rate_t rate);
        rate_is_hd = (rate == RATE_1483) || (rate == RATE_1485);
    endfunction

    function automatic logic rate_supported(input srcl_rate_choice_t choice,
                                            input srcl_rate_t        rate);
        logic ok;
        ok = 1'b0;
        case (choice)
            RC_AUTO:  ok = rate_is_sd(rate) || rate_is_hd(rate);
            RC_SD270: ok = (rate == RATE_270);
            RC_HD:    ok = rate_is_hd(rate);
            default:  ok = 1'b0;
        endcase
        rate_supported = ok;
    endfunction

endpackage

// ---- hdl/srcl_reclocker_ctrl.sv ----
/*
 * Control logic of a four-input serial video reclocker: input choice,
 * lock qualification, standard-definition rate flag, mute and bypass
 * routing of the two serial outputs, and an AHB-Lite register slave.
 * Assumes the analog recovery loop reports lock, signal presence and the
 * detected rate, all synchronous to hclk; serial bits are modelled as
 * hclk-sampled levels.
 */
`timescale 1ns/1ps
`default_nettype none

module srcl_reclocker_ctrl #(
    parameter int unsigned LOCK_HOLD_CYC = srcl_pkg::LOCK_DROP_MAX_CYC
) (
    // Clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // AHB-Lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    // Serial inputs from equalizers
    input  wire logic                 serial_in_0,
    input  wire logic                 serial_in_1,
    input  wire logic                 serial_in_2,
    input  wire logic                 serial_in_3,
    // Recovery loop and retimer
    input  wire logic                 pll_locked,
    input  wire logic                 signal_present,
    input  wire srcl_pkg::srcl_rate_t detected_rate,
    input  wire logic                 retimed_data,
    input  wire logic                 recovered_clock,
    output logic                      retimer_in,
    // Serial outputs and indicators
    output srcl_pkg::srcl_diff_t      primary_retimed_output,
    output srcl_pkg::srcl_diff_t      second_retimed_output,
    output logic                      lock_flag,
    output logic                      standard_def_flag
);
    import srcl_pkg::*;

    // ------------------------------------------------------------------
    // Lock qualification states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        LK_NO_SIGNAL,
        LK_HOLD,
        LK_SEARCH,
        LK_LOCKED
    } srcl_lock_state_t;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    srcl_ctrl_t           ctrl;
    srcl_ctrl_t           ctrl_sync;
    srcl_status_t         status;
    logic                 ref_tick;

    logic                 addr_take;
    logic                 dp_write;
    logic [31:0]          dp_addr;
    logic                 wr_ctrl;
    logic [31:0]          rd_value;
    logic [31:0]          next_hrdata;

    logic [3:0]           serial_bus;
    logic                 selected_in;
    logic                 setting_change;
    logic                 qualified;
    logic [HOLD_W-1:0]    hold_cnt;
    logic [HOLD_W-1:0]    next_hold_cnt;
    srcl_lock_state_t     lock_state;
    srcl_lock_state_t     next_lock_state;
    logic                 next_lock_flag;
    logic                 next_sd_flag;

    logic                 mute_eff;
    logic                 bypass_eff;
    logic                 data_src;
    logic                 second_src;
    logic                 second_mute;

    // ------------------------------------------------------------------
    // Reference timing tick
    // ------------------------------------------------------------------
    srcl_ref_tick u_ref_tick (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .ref_tick (ref_tick)
    );

    // ------------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY
    // ------------------------------------------------------------------
    assign addr_take = hsel & hready & ((htrans & HTRANS_NSEQ_BIT) != 2'h0);
    assign wr_ctrl   = dp_write & (dp_addr == CTRL_ADDR);

    always_comb begin
        if (haddr == CTRL_ADDR) begin
            rd_value = {{(32 - REG_W){1'b0}}, ctrl};
        end else if (haddr == STATUS_ADDR) begin
            rd_value = {{(32 - REG_W){1'b0}}, status};
        end else begin
            rd_value = 32'h0000_0000;
        end
    end

    assign next_hrdata = (addr_take & ~hwrite) ? rd_value : hrdata;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write  <= 1'b0;
            dp_addr   <= 32'h0000_0000;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            dp_write  <= addr_take & hwrite & (hsize == HSIZE_WORD);
            dp_addr   <= addr_take ? haddr : dp_addr;
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Control register; reset gives the pull-up / pull-down defaults
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl <= srcl_ctrl_t'(hwdata[REG_W-1:0]);
        end
    end

    // ------------------------------------------------------------------
    // Control resampled on the reference tick
    // ------------------------------------------------------------------
    assign setting_change = ref_tick & ((ctrl.channel != ctrl_sync.channel) |
                                        (ctrl.rate_choice != ctrl_sync.rate_choice));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_sync <= CTRL_RESET;
        end else if (ref_tick) begin
            ctrl_sync <= ctrl;
        end
    end

    // ------------------------------------------------------------------
    // Input selection
    // ------------------------------------------------------------------
    assign serial_bus  = {serial_in_3, serial_in_2, serial_in_1, serial_in_0};
    assign selected_in = serial_bus[ctrl_sync.channel];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            retimer_in <= 1'b0;
        end else begin
            retimer_in <= selected_in;
        end
    end

    // ------------------------------------------------------------------
    // Lock qualification
    // ------------------------------------------------------------------
    assign qualified = pll_locked & signal_present &
                       rate_supported(ctrl_sync.rate_choice, detected_rate);

    always_comb begin
        next_lock_state = lock_state;
        next_hold_cnt   = hold_cnt;
        if (setting_change) begin
            // Input or rate choice changed: drop lock at once and hold it off
            next_lock_state = LK_HOLD;
            next_hold_cnt   = LOCK_HOLD_CYC[HOLD_W-1:0];
        end else begin
            case (lock_state)
                LK_HOLD: begin
                    if (hold_cnt == '0) begin
                        next_lock_state = LK_SEARCH;
                    end else begin
                        next_hold_cnt = hold_cnt - 1'b1;
                    end
                end
                LK_NO_SIGNAL,
                LK_SEARCH: begin
                    if (qualified) begin
                        next_lock_state = LK_LOCKED;
                    end else if (!signal_present) begin
                        next_lock_state = LK_NO_SIGNAL;
                    end else begin
                        next_lock_state = LK_SEARCH;
                    end
                end
                default: begin
                    if (!qualified) begin
                        next_lock_state = signal_present ? LK_SEARCH : LK_NO_SIGNAL;
                    end
                end
            endcase
        end
    end

    assign next_lock_flag = (next_lock_state == LK_LOCKED);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_state <= LK_NO_SIGNAL;
            hold_cnt   <= '0;
            lock_flag  <= 1'b0;
        end else begin
            lock_state <= next_lock_state;
            hold_cnt   <= next_hold_cnt;
            lock_flag  <= next_lock_flag;
        end
    end

    // ------------------------------------------------------------------
    // Rate flag, registered on the reference tick
    // ------------------------------------------------------------------
    assign next_sd_flag = lock_flag & rate_is_sd(detected_rate);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            standard_def_flag <= 1'b0;
        end else if (ref_tick) begin
            standard_def_flag <= next_sd_flag;
        end
    end

    // ------------------------------------------------------------------
    // Output routing: mute over bypass over retimed data
    // ------------------------------------------------------------------
    assign mute_eff    = ctrl_sync.mute_follow_lock ? ~lock_flag : ~ctrl_sync.mute_n;
    assign bypass_eff  = ctrl_sync.bypass | ~lock_flag;
    assign data_src    = bypass_eff ? selected_in : retimed_data;
    assign second_src  = ctrl_sync.second_out_clock_choice ? recovered_clock : data_src;
    assign second_mute = mute_eff | (ctrl_sync.second_out_clock_choice & bypass_eff);

    srcl_diff_out u_primary_out (
        .hclk    (hclk),
        .hresetn (hresetn),
        .mute    (mute_eff),
        .data    (data_src),
        .pair    (primary_retimed_output)
    );

    srcl_diff_out u_second_out (
        .hclk    (hclk),
        .hresetn (hresetn),
        .mute    (second_mute),
        .data    (second_src),
        .pair    (second_retimed_output)
    );

    // ------------------------------------------------------------------
    // Status view
    // ------------------------------------------------------------------
    assign status = '{
        detected_rate     : detected_rate,
        settling          : (lock_state == LK_HOLD),
        muted             : mute_eff,
        reclocking        : ~bypass_eff,
        standard_def_flag : standard_def_flag,
        lock_flag         : lock_flag
    };

endmodule

`default_nettype wire

// ---- hdl/srcl_ref_tick.sv ----
/*
 * Reference timing enable: one-cycle pulse at 27 MHz average rate made
 * from the 100 MHz clock by a fractional accumulator.
 * Assumes hclk at 100 MHz; jitter of one clock on each tick is accepted.
 */
`timescale 1ns/1ps
`default_nettype none

module srcl_ref_tick (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Enable out
    output logic      ref_tick
);
    import srcl_pkg::*;

    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] sum;
    logic             wrap;

    assign sum  = acc + REF_STEP;
    assign wrap = (sum >= REF_WRAP);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc      <= '0;
            ref_tick <= 1'b0;
        end else begin
            acc      <= wrap ? (sum - REF_WRAP) : sum;
            ref_tick <= wrap;
        end
    end

endmodule

`default_nettype wire

// ---- tb/srcl_far_model.sv ----
/* Model of equalizers, recovery loop and retimer around the block.
   Assumes the bench sets presence, rate and input levels. */
`timescale 1ns/1ps
`default_nettype none
module srcl_far_model
    import srcl_pkg::*;
(
    // Clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // Scenario knobs
    input  wire logic                 present,
    input  wire srcl_pkg::srcl_rate_t rate,
    input  wire logic [3:0]           pat,
    // Loop side
    input  wire logic                 retimer_in,
    output logic [3:0]                serial_in,
    output logic                      pll_locked,
    output logic                      signal_present,
    output srcl_pkg::srcl_rate_t      detected_rate,
    output logic                      retimed_data,
    output logic                      recovered_clock
);
    logic [1:0] acq;
    logic       tog;
    // Loop never locks on odd rates
    wire lockable = present && rate inside {RATE_143, RATE_270, RATE_1483, RATE_1485};
    // No signal: lines wander every cycle
    assign serial_in = present ? pat : {4{tog}};
    assign signal_present = present;
    assign detected_rate = present ? rate : RATE_NONE;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acq <= 2'h0;
            pll_locked <= 1'b0;
            tog <= 1'b0;
            retimed_data <= 1'b0;
            recovered_clock <= 1'b0;
        end else begin
            tog <= ~tog;
            retimed_data <= retimer_in;
            recovered_clock <= ~recovered_clock;
            acq <= !lockable ? 2'h0 : (acq == 2'h3 ? acq : acq + 2'h1);
            pll_locked <= lockable && acq == 2'h3;
        end
    end
endmodule
`default_nettype wire

// ---- tb/srcl_sva.sv ----
/* Checker of the reclocker control ports.
   Assumes hclk as the only clock and hresetn as async reset. */
`timescale 1ns/1ps
`default_nettype none
module srcl_sva
    import srcl_pkg::*;
(
    // Clock and reset
    input wire logic                 hclk,
    input wire logic                 hresetn,
    // Watched ports
    input wire logic                 hreadyout,
    input wire logic                 hresp,
    input wire logic [31:0]          hrdata,
    input wire logic                 serial_in_0,
    input wire logic                 serial_in_1,
    input wire logic                 serial_in_2,
    input wire logic                 serial_in_3,
    input wire logic                 pll_locked,
    input wire logic                 signal_present,
    input wire srcl_pkg::srcl_rate_t detected_rate,
    input wire logic                 retimer_in,
    input wire srcl_pkg::srcl_diff_t primary_retimed_output,
    input wire logic                 lock_flag,
    input wire logic                 standard_def_flag
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence slow_lock_s;
        lock_flag && detected_rate inside {RATE_143, RATE_270};
    endsequence
    sequence fast_lock_s;
        lock_flag && detected_rate inside {RATE_1483, RATE_1485};
    endsequence
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    zero_wait_a: assert property (hreadyout == 1'b1)
        else $error("wait state seen");
    upper_zero_a: assert property (hrdata[31:8] == 24'h0)
        else $error("hrdata upper bits set");
    lock_qual_a: assert property (lock_flag |-> $past(pll_locked && signal_present))
        else $error("lock without qualify");
    lock_loss_a: assert property (!(pll_locked && signal_present) |=> !lock_flag)
        else $error("lock kept after loss");
    no_lock_a: assert property (
        detected_rate inside {RATE_NONE, RATE_177, RATE_360, RATE_540} |=> !lock_flag)
        else $error("lock on unsupported rate");
    rate_low_a: assert property (!lock_flag [*6] |-> !standard_def_flag)
        else $error("rate flag high while unlocked");
    rate_rise_a: assert property ($rose(standard_def_flag) |-> $past(lock_flag))
        else $error("rate flag rose without lock");
    rate_valid_a: assert property ($rose(lock_flag) ##0 slow_lock_s [*5] |-> standard_def_flag)
        else $error("rate flag late after lock");
    fast_rate_a: assert property (fast_lock_s [*6] |-> !standard_def_flag)
        else $error("rate flag high at fast rate");
    route_in_a: assert property ($past(hresetn) &&
        $past(serial_in_0 && serial_in_1 && serial_in_2 && serial_in_3) |-> retimer_in)
        else $error("retimer input not routed");
    pair_apart_a: assert property (primary_retimed_output.p != primary_retimed_output.n)
        else $error("pair lines equal");
endmodule
bind srcl_reclocker_ctrl srcl_sva u_sva (.hclk, .hresetn, .hreadyout, .hresp, .hrdata,
    .serial_in_0, .serial_in_1, .serial_in_2, .serial_in_3, .pll_locked, .signal_present,
    .detected_rate, .retimer_in, .primary_retimed_output, .lock_flag, .standard_def_flag);
`default_nettype wire

// ---- tb/testbench.sv ----
/* Self-checking bench of the reclocker control block.
   Assumes an AHB-Lite master of single word transfers. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import srcl_pkg::*;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, present = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = HSIZE_WORD;
    logic [3:0]  pat = 4'h0, sin;
    logic        hreadyout, hresp, pll_locked, sig_p, rdat, rclk, retimer_in;
    logic        lock_flag, rate_flag, lk, mu, by, sm;
    srcl_rate_t  m_rate = RATE_270, det_rate;
    srcl_rate_t  rt [5] = '{RATE_143, RATE_270, RATE_1483, RATE_1485, RATE_177};
    srcl_diff_t  pri, sec, s1;
    int          bad_count = 0, num_checks = 0;
    always #5 hclk = ~hclk;
    srcl_far_model far (.hclk(hclk), .hresetn(hresetn), .present(present), .rate(m_rate),
        .pat(pat), .retimer_in(retimer_in), .serial_in(sin), .pll_locked(pll_locked),
        .signal_present(sig_p), .detected_rate(det_rate), .retimed_data(rdat),
        .recovered_clock(rclk));
    srcl_reclocker_ctrl #(.LOCK_HOLD_CYC(8)) dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .serial_in_0(sin[0]), .serial_in_1(sin[1]), .serial_in_2(sin[2]),
        .serial_in_3(sin[3]), .pll_locked(pll_locked), .signal_present(sig_p),
        .detected_rate(det_rate), .retimed_data(rdat), .recovered_clock(rclk),
        .retimer_in(retimer_in), .primary_retimed_output(pri),
        .second_retimed_output(sec), .lock_flag(lock_flag), .standard_def_flag(rate_flag));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            bad_count++;
            report_and_stop;
        end
    endtask
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= HTRANS_NSEQ_BIT;
        haddr <= a;
        hwrite <= w;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        q = hrdata;
    endtask
    task rd(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(CTRL_ADDR, 32'h04);
        present <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, CTRL_ADDR, 32'h4 | c);
            repeat (6) @(posedge hclk);
            chk(lock_flag, c == 0);
            pat <= 4'h1 << c;
            repeat (3) @(posedge hclk);
            chk(retimer_in, 1);
            pat <= ~(4'h1 << c);
            repeat (3) @(posedge hclk);
            chk(retimer_in, 0);
        end
        for (int rc = 0; rc < 4; rc++) begin
            for (int i = 0; i < 5; i++) begin
                m_rate <= rt[i];
                bus(1'b1, CTRL_ADDR, {25'h0, rc[1:0], 5'h04});
                repeat (30) @(posedge hclk);
                lk = rc == 0 ? i < 4 : rc == 1 ? i == 1 : rc == 2 ? (i == 2 || i == 3) : 0;
                chk({lock_flag, rate_flag}, {lk, lk && i < 2});
                bus(1'b0, STATUS_ADDR, 32'h0);
                chk(q[3:0], {1'b0, lk, lk && i < 2, lk});
            end
        end
        pat <= 4'hf;
        for (int k = 0; k < 2; k++) begin
            m_rate <= k ? RATE_270 : RATE_177;
            for (int j = 0; j < 16; j++) begin
                bus(1'b1, CTRL_ADDR, {24'h0, j[3], 2'h0, j[2], j[1], j[0], 2'h0});
                repeat (8) @(posedge hclk);
                mu = j[3] ? !k : !j[0];
                by = j[1] || !k;
                sm = mu || (j[2] && by);
                s1 = sec;
                @(posedge hclk);
                chk(pri, mu ? DIFF_MUTED : 2'b10);
                if (j[2] && !sm)
                    chk(s1.p ^ sec.p, 1);
                else
                    chk({s1, sec}, sm ? {DIFF_MUTED, DIFF_MUTED} : 4'b1010);
                bus(1'b0, STATUS_ADDR, 32'h0);
                chk(q[3], mu);
            end
        end
        bus(1'b1, CTRL_ADDR, 32'hffff_ff1b);
        rd(CTRL_ADDR, 32'h1b);
        bus(1'b1, 32'h8, 32'hff);
        rd(32'h8, 32'h0);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk({pri, sec, lock_flag, rate_flag, hreadyout}, {DIFF_MUTED, DIFF_MUTED, 3'b001});
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(CTRL_ADDR, 32'h04);
        report_and_stop;
    end
endmodule
`default_nettype wire
